// >>> verilog/sram_pkg.sv
// Shared constants, state codes and control bundle of the burst memory port.
// Contract
// - Controller strobe low aborts burst, loads address, accesses if all three enables select.
// - Controller strobe low with first enable high deselects into power-down.
// - Processor strobe low aborts burst, loads address and always starts a read; the code reads only if all three enables select.
// - Processor strobe is ignored whenever the first enable is high.
// - Processor strobe cycle with other enables inactive enters power-down.
// - After a load, each edge with advance low steps the burst counter.
// - Advance high without a load holds the burst address as a wait state.
// - In a write only lanes with low byte strobes are updated; a full word write updates every lane.
// - Byte strobes act only while the byte write enable is low.
// - Strobes a, b, c, d each steer their own lettered data lane.
// - Full word write low writes every lane, ignoring enable and strobes.
// - Enables are sampled only on loads; selected is low, low, high.
// - Address, data, enables and controls are captured on the rising clock edge.
// - Order select low gives linear bursts, high or open gives interleaved.
// - Data drivers are on only while output enable is low, asynchronously.
// - Sleep request high enters a data-retaining low-power standby.
// - During sleep every other input is ignored; sleep defaults to inactive.
// - Data bus is two lanes when narrow and four lanes when wide.
// - Interleaved order XORs the first two low bits with the count.
// - Linear order adds the count to the two low bits modulo four.
// - Read unless full word write or enabled strobes select some lane.
package sram_pkg;

  localparam int          ADDR_W_DEFAULT    = 19;
  localparam int          LANES_DEFAULT     = 4;
  localparam int          LANE_W_DEFAULT    = 9;
  localparam int          MAX_LANES         = 4;
  localparam int          BURST_W           = 2;
  localparam logic [1:0]  COUNT_RESET       = 2'h0;
  localparam logic [1:0]  COUNT_STEP        = 2'h1;
  localparam logic        ORDER_LINEAR      = 1'h0;
  localparam logic        ORDER_INTERLEAVED = 1'h1;
  localparam logic        SLEEP_DEFAULT     = 1'h0;

  typedef enum logic [1:0] {
    ST_DESELECT = 2'b00,
    ST_ACTIVE   = 2'b01,
    ST_SNOOZE   = 2'b10
  } state_t;

  // Synchronous control pins, all active low except the third select.
  typedef struct packed {
    logic first_select_n;
    logic second_select_n;
    logic third_select_hi;
    logic ctrl_addr_strobe_n;
    logic proc_addr_strobe_n;
    logic burst_advance_n;
    logic byte_wr_enable_n;
    logic full_word_write_n;
    logic byte_wr_strobe_lane_d_n;
    logic byte_wr_strobe_lane_c_n;
    logic byte_wr_strobe_lane_b_n;
    logic byte_wr_strobe_lane_a_n;
  } sram_ctrl_t;

endpackage

// >>> verilog/burst_sequencer.sv
// Two-bit burst address generator for linear and interleaved order.
`timescale 1ns/1ns
module burst_sequencer (
  input  wire logic       [1:0] first_lo,
  input  wire logic       [1:0] count,
  input  wire logic             order,
  output logic            [1:0] burst_lo
);

  always_comb begin
    if (order == sram_pkg::ORDER_LINEAR) begin
      burst_lo = first_lo + count;
    end else begin
      burst_lo = first_lo ^ count;
    end
  end

endmodule

// >>> verilog/lane_memory.sv
// Storage array with per-lane write enables and a registered read port.
`timescale 1ns/1ns
module lane_memory #(
  parameter int ADDR_W = sram_pkg::ADDR_W_DEFAULT,
  parameter int LANES  = sram_pkg::LANES_DEFAULT,
  parameter int LANE_W = sram_pkg::LANE_W_DEFAULT
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      wr_en,
  input  wire logic [LANES-1:0]          wr_lanes,
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES*LANE_W-1:0]   wr_data,
  input  wire logic                      rd_en,
  output logic      [LANES*LANE_W-1:0]   rd_data
);

  localparam int DEPTH = 1 << ADDR_W;

  // Each lane owns its array so no two processes write one variable; no reset keeps data through sleep.
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LANE_W-1:0] lane_mem [0:DEPTH-1];
      logic [LANE_W-1:0] lane_rd_reg;

      always_ff @(posedge mclk) begin
        if (wr_en && wr_lanes[g]) begin
          lane_mem[addr] <= wr_data[g*LANE_W +: LANE_W];
        end
      end

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          lane_rd_reg <= '0;
        end else if (rd_en) begin
          lane_rd_reg <= lane_mem[addr];
        end
      end

      assign rd_data[g*LANE_W +: LANE_W] = lane_rd_reg;
    end
  endgenerate

endmodule

// >>> verilog/burst_sram_control_port.sv
// Synchronous burst memory port: address load, burst stepping, writes and sleep.
`timescale 1ns/1ns
module burst_sram_control_port #(
  parameter int ADDR_W = sram_pkg::ADDR_W_DEFAULT,
  parameter int LANES  = sram_pkg::LANES_DEFAULT,
  parameter int LANE_W = sram_pkg::LANE_W_DEFAULT
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire sram_pkg::sram_ctrl_t       ctrl,
  input  wire logic [ADDR_W-3:0]          addr_upper,
  input  wire logic                       addr_bit1,
  input  wire logic                       addr_bit0,
  input  wire logic                       burst_order_select,
  input  wire logic                       out_enable_n,
  input  wire logic                       sleep_request,
  input  wire logic [LANES*LANE_W-1:0]    data_in,
  output logic      [LANES*LANE_W-1:0]    data_out,
  output logic                            data_oe_n,
  output logic                            selected,
  output logic                            snoozing
);

  // Lane a sits in the lowest bits; each lane carries its parity bit on top.
  sram_pkg::state_t                 state_reg;
  sram_pkg::state_t                 state_next;
  logic [ADDR_W-3:0]                upper_reg;
  logic [1:0]                       first_lo_reg;
  logic [1:0]                       count_reg;
  logic [1:0]                       count_next;
  logic [1:0]                       first_lo_use;
  logic [1:0]                       burst_lo;
  logic [ADDR_W-3:0]                upper_use;
  logic [ADDR_W-1:0]                cyc_addr;
  logic                             read_valid_reg;
  logic                             select_now;
  logic                             proc_start;
  logic                             ctrl_start;
  logic                             load;
  logic                             stepping;
  logic                             do_access;
  logic                             do_write;
  logic                             do_read;
  logic [LANES-1:0]                 lane_mask;

  // Lanes that a cycle writes; all-zero means the cycle is a read.
  function automatic logic [LANES-1:0] write_lanes(input sram_pkg::sram_ctrl_t c);
    logic [sram_pkg::MAX_LANES-1:0] strobes_n;
    logic [LANES-1:0]               mask;
    strobes_n = {c.byte_wr_strobe_lane_d_n, c.byte_wr_strobe_lane_c_n,
                 c.byte_wr_strobe_lane_b_n, c.byte_wr_strobe_lane_a_n};
    mask = '0;
    if (!c.full_word_write_n) begin
      mask = '1;
    end else if (!c.byte_wr_enable_n) begin
      mask = ~strobes_n[LANES-1:0];
    end
    return mask;
  endfunction

  always_comb begin
    select_now = !ctrl.first_select_n && !ctrl.second_select_n && ctrl.third_select_hi;
    proc_start = !ctrl.proc_addr_strobe_n && !ctrl.first_select_n;
    ctrl_start = !proc_start && !ctrl.ctrl_addr_strobe_n;
    load       = !sleep_request && (proc_start || ctrl_start);
    stepping   = !sleep_request && !load && (state_reg == sram_pkg::ST_ACTIVE)
                 && !ctrl.burst_advance_n;
  end

  always_comb begin
    if (load) begin
      count_next   = sram_pkg::COUNT_RESET;
      first_lo_use = {addr_bit1, addr_bit0};
      upper_use    = addr_upper;
    end else if (stepping) begin
      count_next   = count_reg + sram_pkg::COUNT_STEP;
      first_lo_use = first_lo_reg;
      upper_use    = upper_reg;
    end else begin
      count_next   = count_reg;
      first_lo_use = first_lo_reg;
      upper_use    = upper_reg;
    end
  end

  burst_sequencer u_seq (
    .first_lo (first_lo_use),
    .count    (count_next),
    .order    (burst_order_select),
    .burst_lo (burst_lo)
  );

  assign cyc_addr = {upper_use, burst_lo};

  always_comb begin
    lane_mask = write_lanes(ctrl);
    if (load) begin
      do_access = select_now;
    end else begin
      do_access = !sleep_request && (state_reg == sram_pkg::ST_ACTIVE);
    end
    // A processor-strobe load is always a read; its write follows a cycle later.
    do_write = do_access && !proc_start && (lane_mask != '0);
    do_read  = do_access && !do_write;
  end

  always_comb begin
    if (sleep_request) begin
      state_next = sram_pkg::ST_SNOOZE;
    end else if (load) begin
      if (select_now) begin
        state_next = sram_pkg::ST_ACTIVE;
      end else begin
        state_next = sram_pkg::ST_DESELECT;
      end
    end else if (state_reg == sram_pkg::ST_SNOOZE) begin
      state_next = sram_pkg::ST_DESELECT;
    end else begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= sram_pkg::ST_DESELECT;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upper_reg    <= '0;
      first_lo_reg <= sram_pkg::COUNT_RESET;
      count_reg    <= sram_pkg::COUNT_RESET;
    end else if (load) begin
      upper_reg    <= addr_upper;
      first_lo_reg <= {addr_bit1, addr_bit0};
      count_reg    <= count_next;
    end else if (stepping) begin
      count_reg    <= count_next;
    end
  end

  // Read data stays driven through wait states until a write, a deselect or a sleep request.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      read_valid_reg <= 1'h0;
    end else if (sleep_request) begin
      read_valid_reg <= 1'h0;
    end else if (load || do_access) begin
      read_valid_reg <= do_read;
    end
  end

  lane_memory #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .mclk     (mclk),
    .rst      (rst),
    .wr_en    (do_write),
    .wr_lanes (lane_mask),
    .addr     (cyc_addr),
    .wr_data  (data_in),
    .rd_en    (do_read),
    .rd_data  (data_out)
  );

  // Output enable and sleep act on the drivers without waiting for a clock.
  assign data_oe_n = out_enable_n || sleep_request || !read_valid_reg;
  assign selected  = (state_reg == sram_pkg::ST_ACTIVE);
  assign snoozing  = (state_reg == sram_pkg::ST_SNOOZE) || sleep_request;

endmodule

// >>> tb/burst_sram_control_port_properties.sv
// Pin-level checks of the burst memory port.
`timescale 1ns/1ns
module burst_sram_control_port_properties (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire sram_pkg::sram_ctrl_t ctrl,
  input wire logic                 out_enable_n,
  input wire logic                 sleep_request,
  input wire logic                 data_oe_n,
  input wire logic                 selected,
  input wire logic                 snoozing
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire en_ok = !ctrl.first_select_n && !ctrl.second_select_n && ctrl.third_select_hi;
  wire awake = !sleep_request;
  sequence s_proc_rd; !ctrl.proc_addr_strobe_n && en_ok && awake; endsequence
  sequence s_out_on; !out_enable_n && awake; endsequence
  property p_oe; out_enable_n |-> data_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("drivers on while disabled");
  property p_sleep; sleep_request |-> data_oe_n && snoozing ##1 !selected; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_wake; $fell(sleep_request) |-> !selected; endproperty
  a_wake: assert property (p_wake) else $error("selected after sleep");
  property p_c_off; !ctrl.ctrl_addr_strobe_n && ctrl.first_select_n && awake |=> !selected; endproperty
  a_c_off: assert property (p_c_off) else $error("no power-down");
  property p_p_ign; !ctrl.proc_addr_strobe_n && ctrl.first_select_n && ctrl.ctrl_addr_strobe_n && awake
    |=> $stable(selected); endproperty
  a_p_ign: assert property (p_p_ign) else $error("proc strobe acted");
  property p_p_off; !ctrl.proc_addr_strobe_n && !ctrl.first_select_n && awake
    && (ctrl.second_select_n || !ctrl.third_select_hi) |=> !selected; endproperty
  a_p_off: assert property (p_p_off) else $error("proc deselect missed");
  property p_on; (!ctrl.proc_addr_strobe_n || !ctrl.ctrl_addr_strobe_n) && en_ok && awake |=> selected; endproperty
  a_on: assert property (p_on) else $error("load not selected");
  property p_p_rd; s_proc_rd ##1 s_out_on |-> !data_oe_n; endproperty
  a_p_rd: assert property (p_p_rd) else $error("proc load not read");
  property p_wr; !ctrl.ctrl_addr_strobe_n && en_ok && !ctrl.full_word_write_n && awake |=> data_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("write drove bus");
endmodule
bind burst_sram_control_port burst_sram_control_port_properties props_inst (.mclk(mclk), .rst(rst),
  .ctrl(ctrl), .out_enable_n(out_enable_n), .sleep_request(sleep_request), .data_oe_n(data_oe_n),
  .selected(selected), .snoozing(snoozing));

// >>> tb/bus_master_model.sv
// Bus master model driving the port's pins one cycle at a time.
`timescale 1ns/1ns
module bus_master_model (
  input  wire logic            mclk,
  output sram_pkg::sram_ctrl_t ctrl,
  output logic [3:0]           addr_upper,
  output logic                 addr_bit1,
  output logic                 addr_bit0,
  output logic [35:0]          data_in,
  output logic                 burst_order_select,
  output logic                 out_enable_n,
  output logic                 sleep_request
);
  initial begin
    ctrl = 12'h3ff;
    {addr_upper, addr_bit1, addr_bit0} = 6'h00;
    data_in = 36'h0;
    {burst_order_select, out_enable_n, sleep_request} = 3'h6;
  end
  // Everything moves on the falling edge so the port samples settled values.
  task automatic cyc(input sram_pkg::sram_ctrl_t c, input logic [5:0] a, input logic [35:0] d, input logic [2:0] m);
    @(negedge mclk);
    ctrl = c;
    {addr_upper, addr_bit1, addr_bit0} = a;
    data_in = d;
    {burst_order_select, out_enable_n, sleep_request} = m;
    @(posedge mclk);
    #1;
  endtask
endmodule

// >>> tb/tb_burst_sram_control_port.sv
// Self-checking bench for the burst memory port.
`timescale 1ns/1ns
module tb_burst_sram_control_port;
  localparam logic [11:0] IDLE = 12'h3ff, RD = 12'h2ff, WR = 12'h2ef, BW = 12'h2d6, RN = 12'h2f0, ADV = 12'h3bf,
    OFF = 12'haff, PR = 12'h350, PW = 12'h3ef, PD = 12'h77f, PI = 12'hb7f, CW = 12'h3af;
  logic mclk, rst, ab1, ab0, bos, oen, slp, data_oe_n, selected, snoozing;
  sram_pkg::sram_ctrl_t ctrl;
  logic [3:0] au;
  logic [35:0] data_in, data_out;
  logic [35:0] m [0:63];
  logic [2:0] md;
  int errors = 0, cmp_count = 0, cycles = 0;
  burst_sram_control_port #(.ADDR_W(6)) burst_sram_control_port_inst (.mclk(mclk), .rst(rst), .ctrl(ctrl),
    .addr_upper(au), .addr_bit1(ab1), .addr_bit0(ab0), .burst_order_select(bos), .out_enable_n(oen),
    .sleep_request(slp), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .selected(selected),
    .snoozing(snoozing));
  bus_master_model bus_master_model_inst (.mclk(mclk), .ctrl(ctrl), .addr_upper(au), .addr_bit1(ab1),
    .addr_bit0(ab0), .data_in(data_in), .burst_order_select(bos), .out_enable_n(oen), .sleep_request(slp));
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic go(input logic [11:0] c, input logic [5:0] a, input logic [35:0] d);
    bus_master_model_inst.cyc(c, a, d, md);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_fill();
    for (int i = 0; i < 4; i++) begin
      m[20+i] = 36'h123456789 ^ {6{6'(i)}};
      go(WR, 6'(20 + i), m[20+i]);
    end
    for (int i = 0; i < 4; i++) begin
      go(RD, 6'(20 + i), 36'h0);
      chk("fill", m[20+i], data_out);
    end
    $display("fill done");
  endtask
  task automatic t_bytes();
    go(BW, 6'h15, 36'hfffffffff);
    m[21] = {9'h1ff, m[21][26:9], 9'h1ff};
    go(RN, 6'h15, 36'h0);
    chk("nobwe", m[21], data_out);
    go(12'h2df, 6'h15, 36'h0a5a5a5a5);
    chk("nolane", m[21], data_out);
    go(RD, 6'h15, 36'h0);
    chk("lanes", m[21], data_out);
    $display("bytes done");
  endtask
  task automatic t_burst(input logic o);
    logic [1:0] lo;
    go(OFF, 6'h00, 36'h0);
    md[2] = o;
    go(IDLE, 6'h3f, 36'h0);
    go(RD, 6'h16, 36'h0);
    for (int k = 1; k < 5; k++) begin
      go(ADV, 6'h3f, 36'h0);
      lo = o ? (2'h2 ^ 2'(k)) : (2'h2 + 2'(k));
      chk("burst", m[{4'h5, lo}], data_out);
      go(IDLE, 6'h3f, 36'h0);
      chk("wait", m[{4'h5, lo}], data_out);
    end
    go(RD, 6'h14, 36'h0);
    chk("abort", m[20], data_out);
    $display("burst done");
  endtask
  task automatic t_proc();
    md[1] = 1'b0;
    go(PR, 6'h17, 36'h0);
    chk("proc", m[23], data_out);
    m[23] = 36'h0a5a5a5a5;
    go(PW, 6'h3f, m[23]);
    go(RD, 6'h17, 36'h0);
    chk("procwr", m[23], data_out);
    go(PI, 6'h14, 36'h0);
    chk("ignored", m[23], data_out);
    go(PD, 6'h14, 36'h0);
    chk("pdown", 36'h0, {35'h0, selected});
    go(CW, 6'h14, 36'h0);
    go(RD, 6'h14, 36'h0);
    chk("kept", m[20], data_out);
    $display("proc done");
  endtask
  task automatic t_sleep();
    md[0] = 1'b1;
    go(WR, 6'h14, 36'h0);
    chk("snooze", 36'h3, {34'h0, snoozing, data_oe_n});
    md[0] = 1'b0;
    go(IDLE, 6'h3f, 36'h0);
    chk("wake", 36'h0, {35'h0, selected});
    go(RD, 6'h14, 36'h0);
    chk("retain", m[20], data_out);
    chk("drive", 36'h0, {35'h0, data_oe_n});
    md[1] = 1'b1;
    go(IDLE, 6'h3f, 36'h0);
    chk("float", 36'h1, {35'h0, data_oe_n});
    $display("sleep done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // A hang is cut short well past the roughly sixty cycles the tests need.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    rst = 1'b1;
    md = 3'h6;
    repeat (12) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    t_fill();
    t_bytes();
    t_burst(1'b0);
    t_burst(1'b1);
    t_proc();
    t_sleep();
    stop_test();
  end
endmodule
